// file: common/cct_pkg.sv
// Package for the charge timer and charger control register bank
package cct_pkg;

	// Clock and time base: every long timer counts half-second ticks
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned TICK_MS = 500;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int ELAPSED_W = 18;
	localparam int WD_W = 10;
	typedef logic [ELAPSED_W-1:0] cct_ticks_t;
	typedef logic [WD_W-1:0] cct_wd_t;

	// Safety timer durations in their own units
	localparam int unsigned TOPOFF_MIN_1 = 15;
	localparam int unsigned TOPOFF_MIN_2 = 30;
	localparam int unsigned TOPOFF_MIN_3 = 45;
	localparam int unsigned TRICKLE_HR = 1;
	localparam int unsigned PRECHG_HR = 2;
	localparam int unsigned FAST_HR_0 = 5;
	localparam int unsigned FAST_HR_1 = 8;
	localparam int unsigned FAST_HR_2 = 12;
	localparam int unsigned FAST_HR_3 = 24;

	// Serial-bus watchdog periods in milliseconds, code 0 disables
	localparam int unsigned WD_MS_1 = 500;
	localparam int unsigned WD_MS_2 = 1000;
	localparam int unsigned WD_MS_3 = 2000;
	localparam int unsigned WD_MS_4 = 20000;
	localparam int unsigned WD_MS_5 = 40000;
	localparam int unsigned WD_MS_6 = 80000;
	localparam int unsigned WD_MS_7 = 160000;

	// Register offsets
	localparam logic [7:0] OFS_RESET_CTRL = 8'h09;
	localparam logic [7:0] OFS_TIMER_CFG = 8'h0e;
	localparam logic [7:0] OFS_CTRL0 = 8'h0f;
	localparam logic [7:0] OFS_CTRL1 = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h20;

	// Reset values
	localparam logic [7:0] TIMER_CFG_RST = 8'h3d;
	localparam logic [7:0] CTRL0_RST = 8'ha2;
	localparam logic [1:0] VAC_OVP_RST = 2'h3;
	localparam logic [2:0] WD_SEL_RST = 3'h5;
	// Control 0 bits that the watchdog also returns to default
	localparam logic [7:0] CTRL0_WD_MASK = 8'h2a;

	// Field positions
	localparam int TCFG_TOPOFF_LSB = 6;
	localparam int TCFG_TRICKLE_EN = 5;
	localparam int TCFG_PRE_EN = 4;
	localparam int TCFG_FAST_EN = 3;
	localparam int TCFG_FAST_LSB = 1;
	localparam int TCFG_HALF = 0;
	localparam int C0_AUTO_DIS = 7;
	localparam int C0_FORCE_DIS = 6;
	localparam int C0_CHG_EN = 5;
	localparam int C0_OPT_EN = 4;
	localparam int C0_OPT_START = 3;
	localparam int C0_HIZ = 2;
	localparam int C0_TERM_EN = 1;
	localparam int RC_REG_RESET = 6;
	localparam int C1_VAC_LSB = 4;
	localparam int C1_WD_RESTART = 3;
	localparam int C1_WD_LSB = 0;
	localparam int ST_SAFETY_EXP = 0;
	localparam int ST_TOPOFF_DONE = 1;

	// Charge phase reported by the charging state machine
	typedef enum logic [2:0] {
		cct_ph_idle, cct_ph_trickle, cct_ph_precharge, cct_ph_fast, cct_ph_topoff
	} cct_phase_e;

	// Serial slave states
	typedef enum logic [2:0] {
		cct_ss_idle, cct_ss_addr, cct_ss_addr_ack, cct_ss_wr, cct_ss_wr_ack,
		cct_ss_rd, cct_ss_rd_ack
	} cct_ser_e;

	function automatic cct_ticks_t min_ticks(input int unsigned m);
		return cct_ticks_t'(m * 60 * 1000 / TICK_MS);
	endfunction : min_ticks

	function automatic cct_wd_t ms_ticks(input int unsigned ms);
		return cct_wd_t'(ms / TICK_MS);
	endfunction : ms_ticks

endpackage : cct_pkg

// file: hw/cct_serial_slave.sv
// Two-wire serial slave: pointer write, data write and auto-increment read
`timescale 1ns/1ps
module cct_serial_slave import cct_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = 7'h2a // Arbitrary bus address
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	output logic wr_stb,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data
);

	logic [1:0] sync1_ff, sync2_ff, prev_ff;
	cct_ser_e state_ff, nxt_state;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [7:0] shift_ff, nxt_shift, ptr_ff, nxt_ptr;
	logic ptr_loaded_ff, nxt_ptr_loaded, rw_ff, nxt_rw, oe_n_ff, nxt_oe_n;
	logic wr_stb_ff, nxt_wr_stb;
	logic [7:0] wr_addr_ff, nxt_wr_addr, wr_data_ff, nxt_wr_data;

	// Bit 1 is the clock line, bit 0 the data line, both taken after two stages
	wire scl_r = sync2_ff[1];
	wire sda_r = sync2_ff[0];
	wire scl_rise = scl_r & ~prev_ff[1];
	wire scl_fall = ~scl_r & prev_ff[1];
	wire bus_start = scl_r & prev_ff[1] & prev_ff[0] & ~sda_r;
	wire bus_stop = scl_r & prev_ff[1] & ~prev_ff[0] & sda_r;
	wire byte_full = (cnt_ff == 4'h8);

	// Pin synchroniser and edge history
	always_ff @(posedge clk) begin
		sync1_ff <= {scl_in, sda_in};
		sync2_ff <= sync1_ff;
		prev_ff <= sync2_ff;
	end

	// Byte framing; start and stop override any state
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_shift = shift_ff;
		nxt_ptr = ptr_ff;
		nxt_ptr_loaded = ptr_loaded_ff;
		nxt_rw = rw_ff;
		nxt_oe_n = oe_n_ff;
		nxt_wr_stb = 1'b0;
		nxt_wr_addr = wr_addr_ff;
		nxt_wr_data = wr_data_ff;
		if (bus_start) begin
			nxt_state = cct_ss_addr;
			nxt_cnt = 4'h0;
			nxt_ptr_loaded = 1'b0;
			nxt_oe_n = 1'b1;
		end else if (bus_stop) begin
			nxt_state = cct_ss_idle;
			nxt_oe_n = 1'b1;
		end else begin
			unique case (state_ff)
				cct_ss_idle: begin
				end
				cct_ss_addr, cct_ss_wr: begin
					if (scl_rise && !byte_full) begin
						nxt_shift = {shift_ff[6:0], sda_r};
						nxt_cnt = cnt_ff + 4'h1;
					end else if (scl_fall && byte_full) begin
						nxt_cnt = 4'h0;
						nxt_oe_n = 1'b0;
						if (state_ff == cct_ss_addr) begin
							nxt_rw = shift_ff[0];
							nxt_state = cct_ss_addr_ack;
							if (shift_ff[7:1] != DEV_ADDR) begin
								nxt_state = cct_ss_idle; // Not ours: stay off the line
								nxt_oe_n = 1'b1;
							end
						end else begin
							nxt_state = cct_ss_wr_ack;
							if (!ptr_loaded_ff) begin
								nxt_ptr = shift_ff; // First byte after address is the pointer
								nxt_ptr_loaded = 1'b1;
							end else begin
								nxt_wr_stb = 1'b1;
								nxt_wr_addr = ptr_ff;
								nxt_wr_data = shift_ff;
								nxt_ptr = ptr_ff + 8'h01;
							end
						end
					end
				end
				cct_ss_addr_ack, cct_ss_rd_ack: begin
					if (state_ff == cct_ss_rd_ack && scl_rise && sda_r) begin
						nxt_state = cct_ss_idle; // Master refused: end of read
					end else if (scl_fall) begin
						if (rw_ff) begin
							nxt_shift = rd_data;
							nxt_oe_n = rd_data[7]; // Low enable pulls the line to zero
							nxt_cnt = 4'h1;
							nxt_state = cct_ss_rd;
						end else begin
							nxt_oe_n = 1'b1;
							nxt_state = cct_ss_wr;
						end
					end
				end
				cct_ss_wr_ack: begin
					if (scl_fall) begin
						nxt_oe_n = 1'b1;
						nxt_state = cct_ss_wr;
					end
				end
				cct_ss_rd: begin
					if (scl_fall && byte_full) begin
						nxt_oe_n = 1'b1; // Let the master drive its acknowledge
						nxt_cnt = 4'h0;
						nxt_ptr = ptr_ff + 8'h01;
						nxt_state = cct_ss_rd_ack;
					end else if (scl_fall) begin
						nxt_oe_n = shift_ff[6];
						nxt_shift = {shift_ff[6:0], 1'b0};
						nxt_cnt = cnt_ff + 4'h1;
					end
				end
				default: nxt_state = cct_ss_idle; // Unused code: drop back to idle
			endcase
		end
	end

	// Framing state
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_ff <= cct_ss_idle;
			cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			ptr_ff <= 8'h00;
			ptr_loaded_ff <= 1'b0;
			rw_ff <= 1'b0;
			oe_n_ff <= 1'b1;
			wr_stb_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			wr_data_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			shift_ff <= nxt_shift;
			ptr_ff <= nxt_ptr;
			ptr_loaded_ff <= nxt_ptr_loaded;
			rw_ff <= nxt_rw;
			oe_n_ff <= nxt_oe_n;
			wr_stb_ff <= nxt_wr_stb;
			wr_addr_ff <= nxt_wr_addr;
			wr_data_ff <= nxt_wr_data;
		end
	end

	assign sda_out = 1'b0; // Open drain: only ever pulls low
	assign sda_oe_n = oe_n_ff;
	assign wr_stb = wr_stb_ff;
	assign wr_addr = wr_addr_ff;
	assign wr_data = wr_data_ff;
	assign rd_addr = ptr_ff;

endmodule : cct_serial_slave

// file: hw/cct_charge_ctrl.sv
// Charge safety timer and charger control register bank with serial access
//Contract
//- Top-off field two bits; 0 off, 1-3 give 15, 30, 45 minutes; resets 0.
//- Trickle timer enable bit, default on, fixed one hour length.
//- Pre-charge timer enable bit; 0 off, 1 on; resets to 1.
//- Fast-charge timer enable bit; 0 off, 1 on; resets to 1.
//- Fast duration codes 0-3 mean 5, 8, 12, 24 hours; resets to 12 hours.
//- Half-speed bit halves trickle, pre and fast timers during regulation.
//- Auto discharge bit draws battery current during over-voltage fault; default on.
//- Forced discharge bit draws battery current regardless of over-voltage; default off.
//- Charging allowed only while charge enable is 1; default 1.
//- Optimizer runs only while its enable bit is 1; default 0.
//- Optimizer start is set-only, effective with enable, clears once optimizer starts.
//- High impedance bit enters that mode; cleared by adapter plug-in.
//- Termination applied only while termination enable is 1; default 1.
//- Watchdog restores timers, charge, start, termination; register reset restores all.
//- Writing register reset restores all defaults and restarts timers.
//- Watchdog restart bit restarts watchdog and reads back as zero.
`timescale 1ns/1ps
module cct_charge_ctrl import cct_pkg::*; #(
	parameter int unsigned TICK_LEN = TICK_CYCLES, // Cycles per half-second tick
	parameter logic [6:0] DEV_ADDR = 7'h2a // Arbitrary bus address
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire cct_phase_e charge_phase,
	input wire logic regulation_active,
	input wire logic over_voltage_fault,
	input wire logic adapter_present,
	input wire logic optimizer_started,
	output logic charge_allowed_ff,
	output logic termination_enable_ff,
	output logic discharge_on_ff,
	output logic optimizer_run_ff,
	output logic optimizer_start_req_ff,
	output logic high_impedance_mode_ff,
	output logic safety_expired_ff,
	output logic topoff_done_ff,
	output logic watchdog_expired_ff
);

	logic wr_stb;
	logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
	logic [7:0] tcfg_ff, nxt_tcfg, ctrl0_ff, nxt_ctrl0;
	logic [1:0] vac_ff;
	logic [2:0] wd_sel_ff;
	logic [31:0] pre_ff;
	logic half_ff, adapter_d_ff;
	cct_wd_t wd_cnt_ff;
	cct_ticks_t elapsed_ff, limit;
	cct_wd_t wd_limit;
	cct_phase_e phase_d_ff;

	cct_serial_slave #(.DEV_ADDR(DEV_ADDR)) u_ser (
		.clk(clk),
		.nrst(nrst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe_n(sda_oe_n),
		.wr_stb(wr_stb),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	// Write decode
	wire wr_tcfg = wr_stb && (wr_addr == OFS_TIMER_CFG);
	wire wr_ctrl0 = wr_stb && (wr_addr == OFS_CTRL0);
	wire wr_ctrl1 = wr_stb && (wr_addr == OFS_CTRL1);
	wire reg_reset = wr_stb && (wr_addr == OFS_RESET_CTRL) && wr_data[RC_REG_RESET];
	wire wd_restart = wr_ctrl1 && wr_data[C1_WD_RESTART];

	// Field views of the timer configuration
	wire [1:0] topoff_duration_sel = tcfg_ff[TCFG_TOPOFF_LSB +: 2];
	wire trickle_timer_enable = tcfg_ff[TCFG_TRICKLE_EN];
	wire precharge_timer_enable = tcfg_ff[TCFG_PRE_EN];
	wire fast_timer_enable = tcfg_ff[TCFG_FAST_EN];
	wire [1:0] fast_duration_sel = tcfg_ff[TCFG_FAST_LSB +: 2];
	wire half_speed_timer_enable = tcfg_ff[TCFG_HALF];

	// Read mux; the watchdog restart and register reset command bits always read back as zero
	assign rd_data = (rd_addr == OFS_TIMER_CFG) ? tcfg_ff :
		(rd_addr == OFS_CTRL0) ? {ctrl0_ff[7:1], 1'b0} :
		(rd_addr == OFS_CTRL1) ? {2'b00, vac_ff, 1'b0, wd_sel_ff} :
		(rd_addr == OFS_STATUS) ? {6'h00, topoff_done_ff, safety_expired_ff} :
		8'h00;

	// Half-second time base shared by the watchdog and safety timers
	wire tick = (pre_ff == TICK_LEN - 1);

	// Watchdog period decode
	always_comb begin
		unique case (wd_sel_ff)
			3'h0: wd_limit = '0;
			3'h1: wd_limit = ms_ticks(WD_MS_1);
			3'h2: wd_limit = ms_ticks(WD_MS_2);
			3'h3: wd_limit = ms_ticks(WD_MS_3);
			3'h4: wd_limit = ms_ticks(WD_MS_4);
			3'h5: wd_limit = ms_ticks(WD_MS_5);
			3'h6: wd_limit = ms_ticks(WD_MS_6);
			3'h7: wd_limit = ms_ticks(WD_MS_7);
		endcase
	end
	wire wd_expire = tick && (wd_sel_ff != 3'h0) && (wd_cnt_ff == wd_limit - cct_wd_t'(1));

	// Timer configuration: watchdog or register reset win over a write
	always_comb begin
		nxt_tcfg = tcfg_ff;
		if (reg_reset || wd_expire) begin
			nxt_tcfg = TIMER_CFG_RST;
		end else if (wr_tcfg) begin
			nxt_tcfg = wr_data;
		end
	end

	// Control 0; hardware clears lose to a software set in the same cycle
	wire adapter_plug = adapter_present && !adapter_d_ff;
	always_comb begin
		nxt_ctrl0 = ctrl0_ff;
		nxt_ctrl0[0] = 1'b0;
		if (optimizer_started) begin
			nxt_ctrl0[C0_OPT_START] = 1'b0;
		end
		if (adapter_plug) begin
			nxt_ctrl0[C0_HIZ] = 1'b0;
		end
		if (reg_reset) begin
			nxt_ctrl0 = CTRL0_RST;
		end else if (wd_expire) begin
			nxt_ctrl0 = (nxt_ctrl0 & ~CTRL0_WD_MASK) | (CTRL0_RST & CTRL0_WD_MASK);
		end else if (wr_ctrl0) begin
			nxt_ctrl0 = {wr_data[7:4], ctrl0_ff[C0_OPT_START] | wr_data[C0_OPT_START],
				wr_data[2:1], 1'b0};
			if (wr_data[C0_OPT_START] == 1'b0 && optimizer_started) begin
				nxt_ctrl0[C0_OPT_START] = 1'b0;
			end
		end
	end

	// Register storage
	always_ff @(posedge clk) begin
		if (!nrst) begin
			tcfg_ff <= TIMER_CFG_RST;
			ctrl0_ff <= CTRL0_RST;
			vac_ff <= VAC_OVP_RST;
			wd_sel_ff <= WD_SEL_RST;
			adapter_d_ff <= 1'b0;
		end else begin
			tcfg_ff <= nxt_tcfg;
			ctrl0_ff <= nxt_ctrl0;
			adapter_d_ff <= adapter_present;
			if (reg_reset) begin
				vac_ff <= VAC_OVP_RST;
				wd_sel_ff <= WD_SEL_RST;
			end else if (wr_ctrl1) begin
				vac_ff <= wr_data[C1_VAC_LSB +: 2];
				wd_sel_ff <= wr_data[C1_WD_LSB +: 3];
			end
		end
	end

	// Prescaler and watchdog counter; a restart clears the watchdog count but not the prescaler
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pre_ff <= '0;
			wd_cnt_ff <= '0;
			watchdog_expired_ff <= 1'b0;
		end else begin
			pre_ff <= tick ? '0 : pre_ff + 32'd1;
			watchdog_expired_ff <= wd_expire;
			if (reg_reset || wd_restart || wd_expire || wd_sel_ff == 3'h0) begin
				wd_cnt_ff <= '0;
			end else if (tick) begin
				wd_cnt_ff <= wd_cnt_ff + cct_wd_t'(1);
			end
		end
	end

	// Limit and enable of the timer that owns the present phase
	logic phase_timed;
	always_comb begin
		limit = '0;
		phase_timed = 1'b0;
		unique case (charge_phase)
			cct_ph_idle: begin
			end
			cct_ph_trickle: begin
				limit = min_ticks(TRICKLE_HR * 60);
				phase_timed = trickle_timer_enable;
			end
			cct_ph_precharge: begin
				limit = min_ticks(PRECHG_HR * 60);
				phase_timed = precharge_timer_enable;
			end
			cct_ph_fast: begin
				phase_timed = fast_timer_enable;
				unique case (fast_duration_sel)
					2'h0: limit = min_ticks(FAST_HR_0 * 60);
					2'h1: limit = min_ticks(FAST_HR_1 * 60);
					2'h2: limit = min_ticks(FAST_HR_2 * 60);
					2'h3: limit = min_ticks(FAST_HR_3 * 60);
				endcase
			end
			cct_ph_topoff: begin
				phase_timed = (topoff_duration_sel != 2'h0);
				unique case (topoff_duration_sel)
					2'h0: limit = '0;
					2'h1: limit = min_ticks(TOPOFF_MIN_1);
					2'h2: limit = min_ticks(TOPOFF_MIN_2);
					2'h3: limit = min_ticks(TOPOFF_MIN_3);
				endcase
			end
		endcase
	end

	// Slowed timers advance on every other tick; the top-off timer never slows
	wire slow = half_speed_timer_enable && regulation_active && charge_phase != cct_ph_topoff;
	wire count_tick = tick && (!slow || half_ff);
	wire phase_change = (charge_phase != phase_d_ff);
	wire hit = phase_timed && (elapsed_ff >= limit);
	wire safety_hit = hit && charge_phase != cct_ph_topoff;

	// Elapsed time of the running phase
	always_ff @(posedge clk) begin
		if (!nrst) begin
			phase_d_ff <= cct_ph_idle;
			elapsed_ff <= '0;
			half_ff <= 1'b0;
		end else begin
			phase_d_ff <= charge_phase;
			if (tick && slow) begin
				half_ff <= ~half_ff;
			end
			if (phase_change || reg_reset || wd_expire) begin
				elapsed_ff <= '0;
			end else if (count_tick && !hit) begin
				elapsed_ff <= elapsed_ff + cct_ticks_t'(1);
			end
		end
	end

	// Status and control outputs, each registered
	always_ff @(posedge clk) begin
		if (!nrst) begin
			safety_expired_ff <= 1'b0;
			topoff_done_ff <= 1'b0;
			charge_allowed_ff <= 1'b0;
			termination_enable_ff <= 1'b0;
			discharge_on_ff <= 1'b0;
			optimizer_run_ff <= 1'b0;
			optimizer_start_req_ff <= 1'b0;
			high_impedance_mode_ff <= 1'b0;
		end else begin
			// Expiry holds until the phase returns to idle or a register reset
			if (safety_hit) begin
				safety_expired_ff <= 1'b1;
			end else if (charge_phase == cct_ph_idle || reg_reset) begin
				safety_expired_ff <= 1'b0;
			end
			if (hit && charge_phase == cct_ph_topoff) begin
				topoff_done_ff <= 1'b1;
			end else if (phase_change) begin
				topoff_done_ff <= 1'b0;
			end
			charge_allowed_ff <= ctrl0_ff[C0_CHG_EN] && !ctrl0_ff[C0_HIZ]
				&& !safety_expired_ff && !safety_hit;
			termination_enable_ff <= ctrl0_ff[C0_TERM_EN];
			discharge_on_ff <= ctrl0_ff[C0_FORCE_DIS]
				|| (ctrl0_ff[C0_AUTO_DIS] && over_voltage_fault);
			optimizer_run_ff <= ctrl0_ff[C0_OPT_EN];
			optimizer_start_req_ff <= ctrl0_ff[C0_OPT_START] && ctrl0_ff[C0_OPT_EN];
			high_impedance_mode_ff <= ctrl0_ff[C0_HIZ];
		end
	end

endmodule : cct_charge_ctrl

// file: verif/cct_host_model.sv
// Host processor model that masters the two-wire serial bus
`timescale 1ns/1ps
module cct_host_model import cct_pkg::*; #(
	parameter logic [6:0] DEV = 7'h2a // Arbitrary bus address
) (
	input wire logic clk,
	input wire logic sda_in,
	output logic scl,
	output logic sda_drive_n
);
	// Idle bus: both lines released to their pull-ups
	initial begin
		scl = 1'b1;
		sda_drive_n = 1'b1;
	end

	// Ten cycles a half bit keeps every phase but the four-cycle hold after a clock fall above the eight-cycle minimum
	task automatic half(input int n = 10);
		repeat (n) @(negedge clk);
	endtask : half

	// Start, or repeated start when the clock is low
	task automatic bus_start();
		half(4);
		sda_drive_n = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_drive_n = 1'b0;
		half();
		scl = 1'b0;
	endtask : bus_start

	task automatic bus_stop();
		half(4);
		sda_drive_n = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_drive_n = 1'b1;
		half();
	endtask : bus_stop

	// Data moves only well after the clock falls, never while it is high
	task automatic send(input logic [7:0] b, inout int acks);
		for (int i = 7; i >= -1; i--) begin
			half(4);
			sda_drive_n = (i >= 0) ? b[i] : 1'b1;
			half();
			scl = 1'b1;
			half();
			if (i < 0 && sda_in === 1'b0) acks++;
			scl = 1'b0;
		end
	endtask : send

	task automatic recv(input logic ack, output logic [7:0] b);
		for (int i = 7; i >= -1; i--) begin
			half(4);
			sda_drive_n = (i < 0) ? ~ack : 1'b1;
			half();
			scl = 1'b1;
			half();
			if (i >= 0) b[i] = sda_in;
			scl = 1'b0;
		end
	endtask : recv

	task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d,
		output int acks);
		acks = 0;
		bus_start();
		send({dev, 1'b0}, acks);
		send(ofs, acks);
		send(d, acks);
		bus_stop();
	endtask : wr

	// Pointer write, repeated start, one byte read and a closing not-acknowledge
	task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
		int acks;
		acks = 0;
		bus_start();
		send({DEV, 1'b0}, acks);
		send(ofs, acks);
		bus_start();
		send({DEV, 1'b1}, acks);
		recv(1'b0, d);
		bus_stop();
	endtask : rd
endmodule : cct_host_model

// file: verif/cct_charge_ctrl_monitor.sv
// Assertion checker for the charge control register bank ports
`timescale 1ns/1ps
module cct_charge_ctrl_monitor import cct_pkg::*; #(
	parameter int unsigned TICK_LEN = 4
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sda_oe_n,
	input wire cct_phase_e charge_phase,
	input wire logic adapter_present,
	input wire logic optimizer_started,
	input wire logic charge_allowed_ff,
	input wire logic termination_enable_ff,
	input wire logic optimizer_start_req_ff,
	input wire logic high_impedance_mode_ff,
	input wire logic safety_expired_ff,
	input wire logic topoff_done_ff,
	input wire logic watchdog_expired_ff
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// Blocking conditions, once settled, keep charging off
	AST_HIZ_BLOCKS:
	assert property (high_impedance_mode_ff && $past(high_impedance_mode_ff) |-> !charge_allowed_ff)
		else $error("charging allowed in high impedance mode");
	AST_EXP_BLOCKS:
	assert property (safety_expired_ff && $past(safety_expired_ff) |-> !charge_allowed_ff)
		else $error("charging allowed after timer expiry");
	// Self-clearing bits and watchdog-restored bits follow their hardware cause within a few cycles
	AST_START_CLEARS:
	assert property ($rose(optimizer_started) && optimizer_start_req_ff
		|-> ##[1:4] !optimizer_start_req_ff) else $error("optimizer start not cleared");
	AST_HIZ_PLUGIN:
	assert property ($rose(adapter_present) |-> ##[1:4] !high_impedance_mode_ff)
		else $error("high impedance not cleared on plug-in");
	AST_WD_PULSE:
	assert property (watchdog_expired_ff |=> !watchdog_expired_ff)
		else $error("watchdog expiry longer than one cycle");
	AST_WD_RESTORES:
	assert property (watchdog_expired_ff |-> ##[1:4] (termination_enable_ff
		&& (charge_allowed_ff || high_impedance_mode_ff || safety_expired_ff)))
		else $error("watchdog expiry did not restore defaults");
	// Timer flags belong to the phase that was running
	AST_IDLE_CLEARS:
	assert property ((charge_phase == cct_ph_idle) [*2] |=> !safety_expired_ff)
		else $error("expiry flag held while idle");
	AST_TOPOFF_CLEAR:
	assert property ($changed(charge_phase) |-> ##[1:2] !topoff_done_ff)
		else $error("top-off flag kept across phase change");
	AST_EXP_PHASE:
	assert property ($rose(safety_expired_ff) |-> $past(charge_phase) inside
		{cct_ph_trickle, cct_ph_precharge, cct_ph_fast}) else $error("expiry outside timed phase");
	AST_TOPOFF_PHASE:
	assert property ($rose(topoff_done_ff) |-> $past(charge_phase) == cct_ph_topoff)
		else $error("top-off done outside top-off phase");

	// Main scenarios reached
	cover property ($rose(safety_expired_ff));
	cover property ($rose(topoff_done_ff));
	cover property (watchdog_expired_ff);
	cover property (!sda_oe_n);
endmodule : cct_charge_ctrl_monitor

bind cct_charge_ctrl cct_charge_ctrl_monitor #(.TICK_LEN(TICK_LEN)) mon_u (
	.clk(clk), .nrst(nrst), .sda_oe_n(sda_oe_n), .charge_phase(charge_phase),
	.adapter_present(adapter_present), .optimizer_started(optimizer_started),
	.charge_allowed_ff(charge_allowed_ff), .termination_enable_ff(termination_enable_ff),
	.optimizer_start_req_ff(optimizer_start_req_ff),
	.high_impedance_mode_ff(high_impedance_mode_ff), .safety_expired_ff(safety_expired_ff),
	.topoff_done_ff(topoff_done_ff), .watchdog_expired_ff(watchdog_expired_ff)
);

// file: verif/tb.sv
// Self-checking bench for the charge control register bank
`timescale 1ns/1ps
module tb import cct_pkg::*;;
	localparam int unsigned TL = 2; // Short tick so hour timers fit the run
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic reg_act = 1'b0;
	logic ovf = 1'b0;
	logic plug = 1'b0;
	logic opt_go = 1'b0;
	cct_phase_e phase = cct_ph_idle;
	logic scl, sda_host_n, sda_out, sda_oe_n, sda_w;
	logic chg, term, dis, orun, oreq, high_impedance_mode, sexp, tdone, wdx;
	logic [7:0] rv, c0, tc;
	int fail_count = 0;
	int n_compared = 0;
	int seed = 75045;
	int acks;

	always #12.5 clk = ~clk;
	// Open-drain wire with pull-up: low when either party pulls
	assign sda_w = sda_host_n & (sda_oe_n | sda_out);

	cct_charge_ctrl #(.TICK_LEN(TL)) dut_u (
		.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .charge_phase(phase), .regulation_active(reg_act),
		.over_voltage_fault(ovf), .adapter_present(plug), .optimizer_started(opt_go),
		.charge_allowed_ff(chg), .termination_enable_ff(term), .discharge_on_ff(dis),
		.optimizer_run_ff(orun), .optimizer_start_req_ff(oreq), .high_impedance_mode_ff(high_impedance_mode),
		.safety_expired_ff(sexp), .topoff_done_ff(tdone), .watchdog_expired_ff(wdx)
	);
	cct_host_model host_u (.clk(clk), .sda_in(sda_w), .scl(scl), .sda_drive_n(sda_host_n));

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic cmp_flag(input logic got, input logic exp);
		cmp({7'h00, got}, {7'h00, exp});
	endtask : cmp_flag

	// Control byte after a host write: bit 0 reads zero, start bit is set-only
	function automatic logic [7:0] nxt_c0(input logic [7:0] old, input logic [7:0] w);
		return (w & 8'hf6) | ((old | w) & 8'h08);
	endfunction : nxt_c0

	function automatic logic flag(input int w);
		return (w == 0) ? wdx : (w == 1) ? tdone : sexp;
	endfunction : flag

	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		host_u.wr(7'h2a, ofs, d, acks);
	endtask : wr

	task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
		host_u.rd(ofs, rv);
		cmp(rv, exp);
	endtask : rd_chk

	// Outputs follow the control byte a few cycles after the write
	task automatic chk_outs();
		repeat (4) @(negedge clk);
		cmp_flag(chg, c0[5] & ~c0[2]);
		cmp_flag(term, c0[1]);
		cmp_flag(dis, c0[6] | (c0[7] & ovf));
		cmp_flag(high_impedance_mode, c0[2]);
		cmp_flag(orun, c0[4]);
		cmp_flag(oreq, c0[3] & c0[4]);
	endtask : chk_outs

	// Bounded wait; a missed wanted flag ends the run
	task automatic wait_hi(input int w, input int lim, input logic want);
		int n;
		for (n = 0; n < lim && flag(w) !== 1'b1; n++) @(negedge clk);
		cmp_flag(flag(w), want);
		if (want && n == lim) stop_test();
	endtask : wait_hi

	// Enters a phase from idle; its flag must stay low until close to the limit
	task automatic run_phase(input cct_phase_e ph, input int cyc, input logic want);
		int w;
		w = (ph == cct_ph_topoff) ? 1 : 2;
		phase = cct_ph_idle;
		repeat (4) @(negedge clk);
		phase = ph;
		repeat (cyc - 8) @(negedge clk);
		cmp_flag(flag(w), 1'b0);
		wait_hi(w, 24, want);
		cmp_flag(chg, !(want && w == 2));
		rd_chk(8'h20, {6'h00, want && w == 1, want && w == 2});
		phase = cct_ph_idle;
		repeat (4) @(negedge clk);
		cmp_flag(flag(w), 1'b0);
		$display("test phase %0d limit %0d done", ph, cyc);
	endtask : run_phase

	initial begin
		repeat (99000) @(posedge clk);
		fail_count++;
		stop_test();
	end

	initial begin
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		c0 = 8'ha2;
		chk_outs();
		rd_chk(8'h10, 8'h35);
		wr(8'h10, 8'h38);
		rd_chk(8'h10, 8'h30);
		rd_chk(8'h0e, 8'h3d);
		rd_chk(8'h0f, 8'ha2);
		$display("test defaults done");
		// Every duration code, plus all-ones and all-zeros control corners
		for (int i = 0; i < 4; i++) begin
			rv = 8'($random(seed));
			ovf = rv[7];
			tc = {i[1:0], rv[5:3], i[1:0], rv[0]};
			wr(8'h0e, tc);
			rd_chk(8'h0e, tc);
			rv = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
			c0 = nxt_c0(c0, rv);
			wr(8'h0f, rv);
			rd_chk(8'h0f, c0);
			chk_outs();
		end
		wr(8'h05, 8'hff);
		rd_chk(8'h05, 8'h00);
		host_u.wr(7'h2b, 8'h0f, 8'h00, acks);
		cmp(8'(acks), 8'h00);
		rd_chk(8'h0f, c0);
		$display("test random access done");
		// Start bit survives a zero write and clears when the optimizer starts
		c0 = nxt_c0(c0, 8'h9a);
		wr(8'h0f, 8'h9a);
		chk_outs();
		c0 = nxt_c0(c0, 8'h92);
		wr(8'h0f, 8'h92);
		rd_chk(8'h0f, 8'h9a);
		opt_go = 1'b1;
		@(negedge clk);
		opt_go = 1'b0;
		c0[3] = 1'b0;
		rd_chk(8'h0f, c0);
		$display("test optimizer done");
		c0 = nxt_c0(c0, c0 | 8'h04);
		wr(8'h0f, c0);
		chk_outs();
		plug = 1'b1;
		c0[2] = 1'b0;
		chk_outs();
		rd_chk(8'h0f, c0);
		plug = 1'b0;
		$display("test high impedance done");
		// Shortest watchdog period, then disable and look at what it restored
		c0 = nxt_c0(c0, 8'h58);
		wr(8'h0f, 8'h58);
		wr(8'h0e, 8'hc2);
		wr(8'h10, 8'h31);
		wait_hi(0, 40, 1'b1);
		wr(8'h10, 8'h30);
		rd_chk(8'h0e, 8'h3d);
		c0 = (c0 & 8'hd5) | 8'h22;
		rd_chk(8'h0f, c0);
		chk_outs();
		$display("test watchdog done");
		run_phase(cct_ph_topoff, 3600, 1'b0);
		wr(8'h0e, 8'h7d);
		reg_act = 1'b1;
		run_phase(cct_ph_topoff, 3600, 1'b1);
		run_phase(cct_ph_trickle, 28800, 1'b1);
		reg_act = 1'b0;
		run_phase(cct_ph_trickle, 14400, 1'b1);
		run_phase(cct_ph_fast, 100, 1'b0);
		run_phase(cct_ph_precharge, 100, 1'b0);
		// Register reset brings every register back
		c0 = nxt_c0(c0, 8'h44);
		wr(8'h0f, 8'h44);
		wr(8'h09, 8'h40);
		rd_chk(8'h09, 8'h00);
		rd_chk(8'h0f, 8'ha2);
		rd_chk(8'h0e, 8'h3d);
		rd_chk(8'h10, 8'h35);
		c0 = 8'ha2;
		chk_outs();
		$display("test register reset done");
		stop_test();
	end
endmodule : tb
